// [design/msd_pkg.sv]
package msd_pkg;

  // Machine timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CYCLE_NS      = 500;
  localparam int unsigned CYCLE_CLKS    = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Control store geometry
  localparam int unsigned WORD_W   = 48;
  localparam int unsigned MOD_W    = 4;
  localparam int unsigned WSEL_W   = 8;
  localparam int unsigned ADDR_W   = MOD_W + WSEL_W;
  localparam int unsigned PAR_GRPS = 4;
  localparam int unsigned PAR_GRP_W = WORD_W / PAR_GRPS;
  localparam int unsigned ST_W     = 16;
  localparam int unsigned COND_W   = 32;

  // Microword layout, high bit first in the packed word
  typedef struct packed {
    logic       spare;
    logic       bypass;
    logic [4:0] status_op;
    logic [5:0] next_addr;
    logic [4:0] br2;
    logic [4:0] br1;
    logic [7:0] konst;
    logic [4:0] dest;
    logic       b_comp;
    logic [3:0] alu_fn;
    logic [1:0] b_src;
    logic [4:0] a_src;
  } msd_uword_t;

  // Decoded control handed to the datapath
  typedef struct packed {
    logic [4:0] a_source_field;
    logic [1:0] b_source_field;
    logic [3:0] alu_function_field;
    logic       b_complement_field;
    logic [4:0] destination_field;
    logic [7:0] constant_field;
    logic       alu_bypass_field;
  } msd_ctrl_t;

  // Branch-test codes
  localparam logic [4:0] BR_FORCE_0 = 5'h00;
  localparam logic [4:0] BR_FORCE_1 = 5'h01;
  localparam logic [4:0] BR1_K_TO_W = 5'h08;
  localparam logic [4:0] BR2_A_TO_X = 5'h06;

  // Status op: bit 4 is the value, bits 3:0 the bit index, 0 is no-op
  localparam logic [4:0] ST_NOP   = 5'h00;
  localparam int unsigned ST_VAL_BIT = 4;

  // APB register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_START   = 8'h04;
  localparam logic [7:0] OFS_LD_ADDR = 8'h08;
  localparam logic [7:0] OFS_LD_LO   = 8'h0C;
  localparam logic [7:0] OFS_LD_HI   = 8'h10;
  localparam logic [7:0] OFS_ERR     = 8'h14;
  localparam logic [7:0] OFS_STBITS  = 8'h18;
  localparam logic [7:0] OFS_WORD_LO = 8'h1C;
  localparam logic [7:0] OFS_WORD_HI = 8'h20;

  // Control register fields and reset values
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_PCHK_BIT = 1;
  localparam logic [1:0]  CTRL_RST     = 2'h2;
  localparam int unsigned START_PA_BIT = 12;

endpackage

// [design/msd_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Leg code one forces the matching low word-select bit to one.
// - Conditional leg sets the word-select bit only when tested condition holds.
// - Each microword is 48 bits, captured into 48 sense latches before decode.
// - Store address joins 4-bit module select and 8-bit word select.
// - A new microword is fetched once per 500 ns machine cycle.
// - Word splits into 11 control fields and four parity checks.
// - Five-bit A-source field picks the A bus source.
// - Two-bit B-source field picks the B bus source.
// - Four-bit ALU-function field chooses the ALU operation.
// - Complement bit inverts the B operand before the ALU.
// - Five-bit destination field picks the register loaded at cycle end.
// - Constant field feeds the B operand or the module-select register.
// - First branch test sets or clears word-select bit 6.
// - One first-branch code loads constant low nibble into module select.
// - Second branch test sets or clears word-select bit 7.
// - One second-branch code loads the A bus into word select.
// - Six-bit next-address field forms high word-select bits.
// - Status field sets or resets one status bit per cycle.
// - Bypass routes A bus around the ALU; B-source then coded zero.
// - Address reads as module digit then two word-select digits.
// - Address parity bit makes ones in module and word select even.
module msd_sequencer #(
  parameter int unsigned CYCLE_CLKS = msd_pkg::CYCLE_CLKS
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [7:0]                  a_bus,
  input  wire logic [msd_pkg::COND_W-1:0]  cond_in,
  output msd_pkg::msd_ctrl_t               ctrl,
  output logic                             cycle_end,
  output logic      [msd_pkg::ST_W-1:0]    status_bits,
  output logic                             address_parity_bit,
  output logic                             machine_error
);

  localparam int unsigned CW = $clog2(CYCLE_CLKS + 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(CYCLE_CLKS - 1);

  initial begin
    if (CYCLE_CLKS < 2) begin
      $error("CYCLE_CLKS must be at least 2");
    end
  end

  logic [msd_pkg::WORD_W-1:0]   store [2**msd_pkg::ADDR_W];
  logic [msd_pkg::WORD_W-1:0]   sense_latch_reg;
  logic [msd_pkg::MOD_W-1:0]    mod_reg;
  logic [msd_pkg::WSEL_W-1:0]   wsel_reg;
  logic [msd_pkg::WSEL_W-1:0]   wsel_next;
  logic [msd_pkg::MOD_W-1:0]    mod_next;
  logic [1:0]                   ctrl_reg;
  logic [msd_pkg::ADDR_W-1:0]   ld_addr_reg;
  logic [31:0]                  ld_lo_reg;
  logic [msd_pkg::ST_W-1:0]     status_bits_register;
  logic [msd_pkg::PAR_GRPS-1:0] par_bad_reg;
  logic                         perr_reg;
  logic [CW-1:0]                cyc_reg;
  logic                         fetch_reg;
  logic                         word_ok_reg;
  logic [31:0]                  prdata_reg;
  logic                         run;
  logic                         tick;
  logic                         wr;
  logic                         rd_setup;
  logic                         mapped;
  logic                         start_wr;
  logic                         x6;
  logic                         x7;
  logic [msd_pkg::PAR_GRPS-1:0] par_bad;
  msd_pkg::msd_uword_t          uw;

  assign uw  = msd_pkg::msd_uword_t'(sense_latch_reg);
  assign run = ctrl_reg[msd_pkg::CTRL_RUN_BIT];

  // APB slave, zero wait states
  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign start_wr = wr & (paddr[7:0] == msd_pkg::OFS_START) & ~run;
  assign pready   = 1'b1;

  always_comb begin
    mapped = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0) &&
             (paddr[7:0] <= msd_pkg::OFS_WORD_HI);
  end

  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (rd_setup) begin
      case (paddr[7:0])
        msd_pkg::OFS_CTRL:    prdata_reg <= {30'h0, ctrl_reg};
        msd_pkg::OFS_START:   prdata_reg <= {19'h0, address_parity_bit,
                                             mod_reg, wsel_reg};
        msd_pkg::OFS_LD_ADDR: prdata_reg <= {20'h0, ld_addr_reg};
        msd_pkg::OFS_LD_LO:   prdata_reg <= ld_lo_reg;
        msd_pkg::OFS_ERR:     prdata_reg <= {27'h0, par_bad_reg, perr_reg};
        msd_pkg::OFS_STBITS:  prdata_reg <= {16'h0, status_bits_register};
        msd_pkg::OFS_WORD_LO: prdata_reg <= sense_latch_reg[31:0];
        msd_pkg::OFS_WORD_HI: prdata_reg <= {16'h0, sense_latch_reg[47:32]};
        default:              prdata_reg <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= msd_pkg::CTRL_RST;
    end else if (wr && paddr[7:0] == msd_pkg::OFS_CTRL) begin
      ctrl_reg <= pwdata[1:0];
    end
  end

  // Store loading: low half staged, high half commits and advances
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_addr_reg <= '0;
      ld_lo_reg   <= 32'h00000000;
    end else if (wr && paddr[7:0] == msd_pkg::OFS_LD_ADDR) begin
      ld_addr_reg <= pwdata[msd_pkg::ADDR_W-1:0];
    end else if (wr && paddr[7:0] == msd_pkg::OFS_LD_LO) begin
      ld_lo_reg <= pwdata;
    end else if (wr && paddr[7:0] == msd_pkg::OFS_LD_HI) begin
      ld_addr_reg <= ld_addr_reg + 1'b1;
    end
  end

  always_ff @(posedge pclk) begin
    if (wr && paddr[7:0] == msd_pkg::OFS_LD_HI) begin
      store[ld_addr_reg] <= {pwdata[15:0], ld_lo_reg};
    end
  end

  // Machine cycle timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_reg <= '0;
    end else if (!run || cyc_reg == CYC_LAST) begin
      cyc_reg <= '0;
    end else begin
      cyc_reg <= cyc_reg + 1'b1;
    end
  end

  // Cycle ends only once a valid word is in the latches
  assign tick      = run & word_ok_reg & ~fetch_reg & (cyc_reg == CYC_LAST);
  assign cycle_end = tick;

  // Branch resolution
  always_comb begin
    case (uw.br1)
      msd_pkg::BR_FORCE_0: x6 = 1'b0;
      msd_pkg::BR_FORCE_1: x6 = 1'b1;
      msd_pkg::BR1_K_TO_W: x6 = 1'b0;
      default:             x6 = cond_in[uw.br1];
    endcase
    case (uw.br2)
      msd_pkg::BR_FORCE_0: x7 = 1'b0;
      msd_pkg::BR_FORCE_1: x7 = 1'b1;
      msd_pkg::BR2_A_TO_X: x7 = 1'b0;
      default:             x7 = cond_in[uw.br2];
    endcase
  end

  always_comb begin
    wsel_next = {uw.next_addr, x6, x7};
    if (uw.br2 == msd_pkg::BR2_A_TO_X) begin
      // One-bits are ORed, so a set bit 6 still wins over a zero from A
      wsel_next = a_bus | {uw.next_addr, x6, 1'b0};
    end
    mod_next = mod_reg;
    if (uw.br1 == msd_pkg::BR1_K_TO_W) begin
      mod_next = uw.konst[msd_pkg::MOD_W-1:0];
    end
  end

  // Address registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_reg  <= '0;
      wsel_reg <= '0;
    end else if (start_wr) begin
      mod_reg  <= pwdata[msd_pkg::ADDR_W-1:msd_pkg::WSEL_W];
      wsel_reg <= pwdata[msd_pkg::WSEL_W-1:0];
    end else if (tick) begin
      mod_reg  <= mod_next;
      wsel_reg <= wsel_next;
    end
  end

  assign address_parity_bit = ^{mod_reg, wsel_reg};

  // Fetch one clock after the address settles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_reg <= 1'b0;
    end else begin
      fetch_reg <= tick | start_wr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_ok_reg <= 1'b0;
    end else if (start_wr) begin
      word_ok_reg <= 1'b0;
    end else if (fetch_reg) begin
      word_ok_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_latch_reg <= '0;
    end else if (fetch_reg) begin
      sense_latch_reg <= store[{mod_reg, wsel_reg}];
    end
  end

  // Parity: each quarter of the fetched word must hold an odd count
  always_comb begin
    for (int g = 0; g < msd_pkg::PAR_GRPS; g++) begin
      par_bad[g] = ~^sense_latch_reg[g*msd_pkg::PAR_GRP_W +: msd_pkg::PAR_GRP_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_bad_reg <= '0;
      perr_reg    <= 1'b0;
    end else if (tick && ctrl_reg[msd_pkg::CTRL_PCHK_BIT] && (|par_bad)) begin
      par_bad_reg <= par_bad_reg | par_bad;
      perr_reg    <= 1'b1;
    end else if (wr && paddr[7:0] == msd_pkg::OFS_ERR && pwdata[0]) begin
      par_bad_reg <= '0;
      perr_reg    <= 1'b0;
    end
  end

  assign machine_error = perr_reg;

  // Status bits register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_bits_register <= '0;
    end else if (tick && uw.status_op != msd_pkg::ST_NOP) begin
      status_bits_register[uw.status_op[3:0]] <=
        uw.status_op[msd_pkg::ST_VAL_BIT];
    end else if (wr && paddr[7:0] == msd_pkg::OFS_STBITS) begin
      status_bits_register <= pwdata[msd_pkg::ST_W-1:0];
    end
  end

  assign status_bits = status_bits_register;

  // Decoded fields straight from the sense latches
  always_comb begin
    ctrl.a_source_field     = uw.a_src;
    ctrl.b_source_field     = uw.b_src;
    ctrl.alu_function_field = uw.alu_fn;
    ctrl.b_complement_field = uw.b_comp;
    ctrl.destination_field  = uw.dest;
    ctrl.constant_field     = uw.konst;
    ctrl.alu_bypass_field   = uw.bypass;
  end

endmodule

`default_nettype wire

// [dv/msd_sequencer_properties.sv]
`timescale 1ns/1ns
`default_nettype none
module msd_sequencer_properties #(
  parameter int unsigned CYCLE_CLKS = 25
) (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic                       pready,
  input wire msd_pkg::msd_ctrl_t         ctrl,
  input wire logic                       cycle_end,
  input wire logic [msd_pkg::ST_W-1:0]   status_bits,
  input wire logic                       machine_error
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam int GAP = CYCLE_CLKS - 1;
  logic       wr;
  logic [7:0] gap_reg;
  assign wr = psel && penable && pwrite;
  // Clocks since the last cycle end, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      gap_reg <= 8'h00;
    else if (cycle_end)
      gap_reg <= 8'h00;
    else if (gap_reg != 8'hFF)
      gap_reg <= gap_reg + 8'h01;
  end
  sequence end_s;
    cycle_end;
  endsequence
  sequence idle_s;
    !cycle_end [*3];
  endsequence
  cycle_gap_a: assert property (end_s |=> idle_s)
    else $error("machine cycle too short");
  cycle_min_a: assert property (cycle_end |-> gap_reg >= GAP)
    else $error("cycle end came early");
  latch_time_a: assert property (!$stable(ctrl) |-> $past(cycle_end, 2) || $past(wr, 2))
    else $error("decoded fields changed outside a fetch");
  status_time_a: assert property (!$stable(status_bits) |-> $past(cycle_end) || $past(wr))
    else $error("status bits changed outside a cycle end");
  status_one_a: assert property ($past(cycle_end) && !$past(wr) |->
    $countones(status_bits ^ $past(status_bits)) <= 1)
    else $error("more than one status bit changed");
  error_hold_a: assert property (machine_error && !wr |=> machine_error)
    else $error("machine error dropped by itself");
  error_cause_a: assert property ($rose(machine_error) |-> $past(cycle_end))
    else $error("machine error raised outside a check");
  ready_now_a: assert property (psel && penable |-> pready)
    else $error("bus access not answered at once");
endmodule
`default_nettype wire

// [dv/msd_datapath_model.sv]
`timescale 1ns/1ns
`default_nettype none
module msd_datapath_model (
  input  wire msd_pkg::msd_ctrl_t ctrl,
  input  wire logic [7:0]         a_val,
  input  wire logic [31:0]        cond_val,
  output logic      [7:0]         a_bus,
  output logic      [31:0]        cond_in
);
  // Source code zero puts zero on the A bus
  assign a_bus = (ctrl.a_source_field == 5'h00) ? 8'h00 : a_val;
  assign cond_in = cond_val;
endmodule
`default_nettype wire

// [dv/test_microword_sequencer_decoder.sv]
`timescale 1ns/1ns
`default_nettype none
module test_microword_sequencer_decoder;
  logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0]              paddr, pwdata, prdata, cond_val, cond_in, rdata;
  logic [7:0]               a_bus, a_val;
  logic                     cycle_end, address_parity_bit, machine_error, err, err_exp;
  logic [msd_pkg::ST_W-1:0] status_bits;
  msd_pkg::msd_ctrl_t       ctrl;
  msd_pkg::msd_uword_t      w [4];
  logic [11:0]              wa [4];
  logic [15:0]              st_exp [3];
  int                       bad_count, cmp_count, cyc;
  msd_sequencer #(.CYCLE_CLKS(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .a_bus(a_bus), .cond_in(cond_in), .ctrl(ctrl), .cycle_end(cycle_end),
    .status_bits(status_bits), .address_parity_bit(address_parity_bit),
    .machine_error(machine_error));
  msd_datapath_model dp_u (.ctrl(ctrl), .a_val(a_val), .cond_val(cond_val),
    .a_bus(a_bus), .cond_in(cond_in));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  function automatic msd_pkg::msd_ctrl_t dec(msd_pkg::msd_uword_t u);
    dec = '{u.a_src, u.b_src, u.alu_fn, u.b_comp, u.dest, u.konst, u.bypass};
  endfunction
  // A quarter with an even count of ones is a parity fault
  function automatic logic bad(logic [47:0] u);
    bad = ~^u[11:0] | ~^u[23:12] | ~^u[35:24] | ~^u[47:36];
  endfunction
  task automatic chk(string n, logic [47:0] e, logic [47:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
      bad_count++;
    end
  endtask
  task automatic apb(logic wr_en, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic load(logic [11:0] a, logic [47:0] u);
    apb(1'b1, msd_pkg::OFS_LD_ADDR, {20'h0, a});
    apb(1'b1, msd_pkg::OFS_LD_LO, u[31:0]);
    apb(1'b1, msd_pkg::OFS_LD_HI, {16'h0, u[47:32]});
  endtask
  // Returns three edges after a cycle end, once the next word is latched
  task automatic wait_end();
    do @(posedge pclk); while (cycle_end !== 1'b1);
    repeat (3) @(posedge pclk);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    a_val = 8'h58;
    cond_val = 32'h0000_0004;
    w[0] = '{1'b0, 1'b0, 5'h1F, 6'h05, 5'h00, 5'h01, 8'hA5, 5'h03, 1'b1, 4'h2, 2'h2, 5'h04};
    w[1] = '{1'b1, 1'b0, 5'h13, 6'h0A, 5'h02, 5'h08, 8'h03, 5'h07, 1'b0, 4'h3, 2'h1, 5'h0D};
    // A bus jump: next address coded zero, bypass with B source zero
    w[2] = '{1'b0, 1'b1, 5'h0F, 6'h00, 5'h06, 5'h00, 8'h00, 5'h09, 1'b0, 4'h0, 2'h0, 5'h05};
    w[3] = '{1'b0, 1'b0, 5'h00, 6'h16, 5'h00, 5'h00, 8'h3C, 5'h01, 1'b0, 4'h1, 2'h3, 5'h00};
    wa = '{12'h000, 12'h016, 12'h329, 12'h358};
    st_exp = '{16'h8000, 16'h8008, 16'h0008};
    err_exp = bad(w[0]) | bad(w[1]) | bad(w[2]) | bad(w[3]);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, msd_pkg::OFS_CTRL, 32'h0);
    chk("ctrl_reset", 32'h2, rdata);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped", {1'b1, 32'h0}, {err, rdata});
    for (int i = 0; i < 4; i++)
      load(wa[i], w[i]);
    apb(1'b1, msd_pkg::OFS_START, 32'h0);
    repeat (2) @(posedge pclk);
    chk("first_word", dec(w[0]), ctrl);
    $display("test load done");
    apb(1'b1, msd_pkg::OFS_CTRL, 32'h3);
    for (int i = 1; i < 4; i++) begin
      wait_end();
      chk("fields", dec(w[i]), ctrl);
      chk("status", st_exp[i-1], status_bits);
    end
    wait_end();
    apb(1'b1, msd_pkg::OFS_CTRL, 32'h2);
    apb(1'b0, msd_pkg::OFS_START, 32'h0);
    chk("address", {^wa[3], wa[3]}, rdata[12:0]);
    chk("addr_parity", ^wa[3], address_parity_bit);
    apb(1'b0, msd_pkg::OFS_STBITS, 32'h0);
    chk("stbits", 32'h8, rdata);
    $display("test run done");
    chk("error", err_exp, machine_error);
    apb(1'b1, msd_pkg::OFS_ERR, 32'h1);
    chk("error_clear", 1'b0, machine_error);
    // Run with parity checking off: no error may be raised
    apb(1'b1, msd_pkg::OFS_CTRL, 32'h1);
    wait_end();
    wait_end();
    chk("error_off", 1'b0, machine_error);
    // Start write while running is refused, address stays put
    apb(1'b1, msd_pkg::OFS_START, 32'h0);
    apb(1'b0, msd_pkg::OFS_START, 32'h0);
    chk("start_refused", {^wa[3], wa[3]}, rdata[12:0]);
    apb(1'b1, msd_pkg::OFS_CTRL, 32'h2);
    $display("test error done");
    end_sim();
  end
endmodule
bind msd_sequencer msd_sequencer_properties #(.CYCLE_CLKS(CYCLE_CLKS)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .ctrl(ctrl), .cycle_end(cycle_end), .status_bits(status_bits),
  .machine_error(machine_error));
`default_nettype wire
